// ===== shared/spl_cfg.svh
// Offsets, field positions, reset values and word addresses of the loader
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

`define SPL_ADDR_W 8
`define SPL_DATA_W 16

`define SPL_WORD_POWER 8'h12
`define SPL_WORD_PINS_A 8'h20
`define SPL_WORD_PINS_B 8'h10

`define SPL_REG_DEV_CTRL 8'h00
`define SPL_REG_EXT_CTRL 8'h04
`define SPL_REG_PM_CSR 8'h08
`define SPL_REG_PM_DATA 8'h0c
`define SPL_REG_PIN_IN 8'h10
`define SPL_REG_STATUS 8'h14

`define SPL_DEV_PHY_PM_BIT 0
`define SPL_DEV_WAKE_ADV_BIT 1
`define SPL_PM_SEL_LO 9
`define SPL_PM_SEL_HI 12
`define SPL_PM_SEL_COMMON 4'h8
`define SPL_STAT_READY_BIT 0
`define SPL_STAT_SIG_BIT 1

`define SPL_W_DIR_HI 15
`define SPL_W_DIR_NEXT 14
`define SPL_W_DIR_1 9
`define SPL_W_DIR_0 8
`define SPL_W_VAL_HI 7
`define SPL_W_VAL_NEXT 6
`define SPL_W_PHY_PM 3
`define SPL_W_WAKE_ADV 2
`define SPL_W_VAL_1 1
`define SPL_W_VAL_0 0

`define SPL_PIN_WORD_RESET 16'h000c
`define SPL_POWER_RESET 16'h0000

`endif

// ===== shared/spl_pkg.sv
// Types shared by the loader and its word reader
package spl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ_PINS,
        ST_READ_POWER,
        ST_APPLY,
        ST_READY
    } spl_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } spl_bus_req_s;

    typedef struct packed {
        logic req;
        logic [7:0] addr;
    } spl_mem_req_s;

    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } spl_mem_rsp_s;
endpackage : spl_pkg

// ===== hdl/spl_word_reader.sv
// Single word fetch from the configuration memory
`timescale 1ns/10ps
`include "spl_cfg.svh"
module spl_word_reader (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Command
    input wire logic i_start,
    input wire logic [`SPL_ADDR_W-1:0] i_addr,
    output spl_pkg::spl_mem_req_s o_mem_req,
    input wire spl_pkg::spl_mem_rsp_s i_mem_rsp,
    // Result
    output logic o_done,
    output logic [`SPL_DATA_W-1:0] o_data
);
    spl_pkg::spl_mem_req_s req_reg;
    logic done_reg;
    logic [`SPL_DATA_W-1:0] data_reg;

    // Request held until the memory acknowledges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_reg <= '0;
        end else if (i_start) begin
            req_reg.req <= 1'b1;
            req_reg.addr <= i_addr;
        end else if (req_reg.req && i_mem_rsp.ack) begin
            req_reg.req <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_reg <= 1'b0;
            data_reg <= '0;
        end else begin
            done_reg <= req_reg.req && i_mem_rsp.ack;
            if (req_reg.req && i_mem_rsp.ack) begin
                data_reg <= i_mem_rsp.data;
            end
        end
    end

    assign o_mem_req = req_reg;
    assign o_done = done_reg;
    assign o_data = data_reg;
endmodule : spl_word_reader

// ===== hdl/spl_loader.sv
// Power-up loader for soft pin defaults and the common power figure
`timescale 1ns/10ps
`include "spl_cfg.svh"
module spl_loader #(
    parameter bit DUAL_PORT = 1'b0,
    parameter bit REDUCED_PINS = 1'b0,
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Status from neighbouring logic
    input wire logic i_sig_valid,
    input wire logic i_pm_enable,
    input wire logic i_port_b,
    // Configuration memory
    output spl_pkg::spl_mem_req_s o_mem_req,
    input wire spl_pkg::spl_mem_rsp_s i_mem_rsp,
    // Register port
    input wire spl_pkg::spl_bus_req_s i_bus,
    output logic [`SPL_DATA_W-1:0] o_rdata,
    // Soft pins
    input wire logic [NUM_PINS-1:0] i_soft_pin_in,
    output logic [NUM_PINS-1:0] o_soft_pin_out,
    output logic [NUM_PINS-1:0] o_soft_pin_oe,
    // Control bits
    output logic o_phy_power_mgmt_enable,
    output logic o_deep_sleep_wake_advert,
    output logic o_regs_ready
);
    localparam int PIN_HI = REDUCED_PINS ? 3 : 7;
    localparam int PIN_NEXT = PIN_HI - 1;
    localparam logic [NUM_PINS-1:0] PIN_MASK =
        REDUCED_PINS ? NUM_PINS'(8'h0f) : NUM_PINS'(8'hff);

    logic [1:0] rst_sync_reg;
    logic rst_n;
    spl_pkg::spl_state_e state_reg;
    logic rd_start_reg;
    logic [`SPL_ADDR_W-1:0] rd_addr_reg;
    logic rd_done;
    logic [`SPL_DATA_W-1:0] rd_data;
    logic port_b_reg;
    logic sig_ok_reg;
    logic [`SPL_DATA_W-1:0] pin_word_reg;
    logic [`SPL_DATA_W-1:0] power_reg;
    logic [NUM_PINS-1:0] pin_dir_reg;
    logic [NUM_PINS-1:0] pin_val_reg;
    logic [NUM_PINS-1:0] pin_meta_reg;
    logic [NUM_PINS-1:0] pin_sync_reg;
    logic [NUM_PINS-1:0] pin_out_reg;
    logic [NUM_PINS-1:0] pin_oe_reg;
    logic phy_pm_reg;
    logic wake_adv_reg;
    logic ready_reg;
    logic [3:0] pm_sel_reg;
    logic [`SPL_DATA_W-1:0] pm_data;
    logic [`SPL_DATA_W-1:0] rdata_next;
    logic [`SPL_DATA_W-1:0] rdata_reg;
    logic sw_wr;

    // Reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    spl_word_reader u_reader (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_start(rd_start_reg),
        .i_addr(rd_addr_reg),
        .o_mem_req(o_mem_req),
        .i_mem_rsp(i_mem_rsp),
        .o_done(rd_done),
        .o_data(rd_data)
    );

    // Load sequence
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= spl_pkg::ST_IDLE;
            rd_start_reg <= 1'b0;
            rd_addr_reg <= '0;
            port_b_reg <= 1'b0;
            sig_ok_reg <= 1'b0;
            pin_word_reg <= `SPL_PIN_WORD_RESET;
            power_reg <= `SPL_POWER_RESET;
            ready_reg <= 1'b0;
        end else begin
            rd_start_reg <= 1'b0;
            case (state_reg)
                spl_pkg::ST_IDLE: begin
                    port_b_reg <= i_port_b;
                    sig_ok_reg <= i_sig_valid;
                    if (i_sig_valid) begin
                        rd_start_reg <= 1'b1;
                        if (DUAL_PORT && i_port_b) begin
                            rd_addr_reg <= `SPL_WORD_PINS_B;
                        end else begin
                            rd_addr_reg <= `SPL_WORD_PINS_A;
                        end
                        state_reg <= spl_pkg::ST_READ_PINS;
                    end else begin
                        state_reg <= spl_pkg::ST_APPLY;
                    end
                end
                spl_pkg::ST_READ_PINS: begin
                    if (rd_done) begin
                        pin_word_reg <= rd_data;
                        rd_start_reg <= 1'b1;
                        rd_addr_reg <= `SPL_WORD_POWER;
                        state_reg <= spl_pkg::ST_READ_POWER;
                    end
                end
                spl_pkg::ST_READ_POWER: begin
                    if (rd_done) begin
                        power_reg <= rd_data;
                        state_reg <= spl_pkg::ST_APPLY;
                    end
                end
                spl_pkg::ST_APPLY: begin
                    ready_reg <= 1'b1;
                    state_reg <= spl_pkg::ST_READY;
                end
                spl_pkg::ST_READY: begin
                    ready_reg <= 1'b1;
                end
                default: begin
                    state_reg <= spl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign sw_wr = i_bus.wr && ready_reg;

    // Extended control: soft pin direction and data
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_dir_reg <= '0;
            pin_val_reg <= '0;
        end else if (state_reg == spl_pkg::ST_APPLY) begin
            pin_dir_reg <= '0;
            pin_val_reg <= '0;
            pin_dir_reg[PIN_HI] <= pin_word_reg[`SPL_W_DIR_HI];
            pin_dir_reg[PIN_NEXT] <= pin_word_reg[`SPL_W_DIR_NEXT];
            pin_dir_reg[1] <= pin_word_reg[`SPL_W_DIR_1];
            pin_dir_reg[0] <= pin_word_reg[`SPL_W_DIR_0];
            pin_val_reg[PIN_HI] <= pin_word_reg[`SPL_W_VAL_HI];
            pin_val_reg[PIN_NEXT] <= pin_word_reg[`SPL_W_VAL_NEXT];
            pin_val_reg[1] <= pin_word_reg[`SPL_W_VAL_1];
            pin_val_reg[0] <= pin_word_reg[`SPL_W_VAL_0];
        end else if (sw_wr && i_bus.addr == `SPL_REG_EXT_CTRL) begin
            pin_dir_reg <= i_bus.wdata[15:8] & PIN_MASK;
            pin_val_reg <= i_bus.wdata[7:0] & PIN_MASK;
        end
    end

    // Device control bits
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_pm_reg <= 1'b1;
            wake_adv_reg <= 1'b1;
        end else if (state_reg == spl_pkg::ST_APPLY) begin
            phy_pm_reg <= pin_word_reg[`SPL_W_PHY_PM];
            wake_adv_reg <= pin_word_reg[`SPL_W_WAKE_ADV];
        end else if (sw_wr && i_bus.addr == `SPL_REG_DEV_CTRL) begin
            phy_pm_reg <= i_bus.wdata[`SPL_DEV_PHY_PM_BIT];
            wake_adv_reg <= i_bus.wdata[`SPL_DEV_WAKE_ADV_BIT];
        end
    end

    // Power management selector
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_sel_reg <= 4'h0;
        end else if (sw_wr && i_bus.addr == `SPL_REG_PM_CSR) begin
            pm_sel_reg <= i_bus.wdata[`SPL_PM_SEL_HI:`SPL_PM_SEL_LO];
        end
    end

    // Pin drivers and input synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            always_ff @(posedge i_ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                    pin_oe_reg[gi] <= 1'b0;
                    pin_out_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= i_soft_pin_in[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    pin_oe_reg[gi] <= pin_dir_reg[gi];
                    pin_out_reg[gi] <= pin_val_reg[gi] & pin_dir_reg[gi];
                end
            end
        end
    endgenerate

    // Power data readback
    always_comb begin
        pm_data = '0;
        if (sig_ok_reg && i_pm_enable &&
            pm_sel_reg == `SPL_PM_SEL_COMMON) begin
            pm_data = power_reg;
        end
    end

    always_comb begin
        rdata_next = '0;
        case (i_bus.addr)
            `SPL_REG_DEV_CTRL: begin
                rdata_next[`SPL_DEV_PHY_PM_BIT] = phy_pm_reg;
                rdata_next[`SPL_DEV_WAKE_ADV_BIT] = wake_adv_reg;
            end
            `SPL_REG_EXT_CTRL: begin
                rdata_next = {pin_dir_reg, pin_val_reg};
            end
            `SPL_REG_PM_CSR: begin
                rdata_next[`SPL_PM_SEL_HI:`SPL_PM_SEL_LO] = pm_sel_reg;
            end
            `SPL_REG_PM_DATA: begin
                rdata_next = pm_data;
            end
            `SPL_REG_PIN_IN: begin
                rdata_next = {8'h00, pin_sync_reg};
            end
            `SPL_REG_STATUS: begin
                rdata_next[`SPL_STAT_READY_BIT] = ready_reg;
                rdata_next[`SPL_STAT_SIG_BIT] = sig_ok_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (i_bus.rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_soft_pin_out = pin_out_reg;
    assign o_soft_pin_oe = pin_oe_reg;
    assign o_phy_power_mgmt_enable = phy_pm_reg;
    assign o_deep_sleep_wake_advert = wake_adv_reg;
    assign o_regs_ready = ready_reg;

    // Checks
    pm_common_read_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_bus.rd && i_bus.addr == `SPL_REG_PM_DATA && sig_ok_reg &&
         i_pm_enable && pm_sel_reg == `SPL_PM_SEL_COMMON)
        |=> o_rdata == power_reg)
        else $error("common power not returned on selector 8");

    pm_other_sel_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_bus.rd && i_bus.addr == `SPL_REG_PM_DATA &&
         pm_sel_reg != `SPL_PM_SEL_COMMON) |=> o_rdata == '0)
        else $error("power data returned for wrong selector");

    power_capture_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state_reg == spl_pkg::ST_READ_POWER && rd_done)
        |=> power_reg == $past(rd_data))
        else $error("common power word not captured");

    dir_high_load_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_APPLY
        |=> pin_dir_reg[PIN_HI] == pin_word_reg[`SPL_W_DIR_HI] &&
            pin_dir_reg[PIN_NEXT] == pin_word_reg[`SPL_W_DIR_NEXT])
        else $error("upper pin direction not loaded");

    dir_low_load_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_APPLY
        |=> pin_dir_reg[1:0] == pin_word_reg[9:8])
        else $error("low pin direction not loaded");

    val_load_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_APPLY
        |=> pin_val_reg[PIN_HI] == pin_word_reg[`SPL_W_VAL_HI] &&
            pin_val_reg[PIN_NEXT] == pin_word_reg[`SPL_W_VAL_NEXT] &&
            pin_val_reg[1:0] == pin_word_reg[1:0])
        else $error("pin data not loaded");

    pin_drive_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        ##1 (o_soft_pin_out & ~o_soft_pin_oe) == '0 &&
        o_soft_pin_oe == $past(pin_dir_reg))
        else $error("pin driven while set as input");

    ctrl_load_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_APPLY
        |=> o_phy_power_mgmt_enable == $past(pin_word_reg[3]) &&
            o_deep_sleep_wake_advert == $past(pin_word_reg[2]))
        else $error("device control defaults not loaded");

    word_addr_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state_reg == spl_pkg::ST_IDLE && i_sig_valid)
        |=> rd_addr_reg == ((DUAL_PORT && port_b_reg) ?
            `SPL_WORD_PINS_B : `SPL_WORD_PINS_A))
        else $error("pin word address wrong for port");

    ready_after_load_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        $rose(ready_reg) |-> $past(state_reg) == spl_pkg::ST_APPLY)
        else $error("registers released before load");

    early_write_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (!ready_reg && state_reg != spl_pkg::ST_APPLY)
        |=> $stable(pin_dir_reg) && $stable(phy_pm_reg))
        else $error("software write taken before release");

    load_path_c: cover property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_READ_POWER ##[1:50] ready_reg);
    no_sig_c: cover property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == spl_pkg::ST_IDLE && !i_sig_valid ##2 ready_reg);
    pm_read_c: cover property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        i_bus.rd && i_bus.addr == `SPL_REG_PM_DATA && pm_data != '0);
endmodule : spl_loader

// ===== bench/spl_mem_model.sv
// Configuration memory model answering word reads after a set delay
`timescale 1ns/10ps
module spl_mem_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Contents and answer delay
    input wire logic [7:0] i_delay,
    input wire logic [15:0] i_word_a,
    input wire logic [15:0] i_word_b,
    input wire logic [15:0] i_word_power,
    // Memory link
    input wire spl_pkg::spl_mem_req_s i_mem_req,
    output spl_pkg::spl_mem_rsp_s o_mem_rsp
);
    logic [7:0] wait_reg;
    logic served_reg;
    logic [15:0] word_sel;

    always_comb begin
        case (i_mem_req.addr)
            8'h20: word_sel = i_word_a;
            8'h10: word_sel = i_word_b;
            8'h12: word_sel = i_word_power;
            default: word_sel = 16'h0bad;
        endcase
    end

    // Data flips every idle cycle so a stale read never matches
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg <= 8'h00;
            served_reg <= 1'b0;
            o_mem_rsp <= '{ack: 1'b0, data: 16'h5a5a};
        end else begin
            o_mem_rsp.ack <= 1'b0;
            o_mem_rsp.data <= ~o_mem_rsp.data;
            if (i_mem_req.req !== 1'b1) begin
                wait_reg <= 8'h00;
                served_reg <= 1'b0;
            end else if (!served_reg && wait_reg >= i_delay) begin
                o_mem_rsp <= '{ack: 1'b1, data: word_sel};
                served_reg <= 1'b1;
            end else if (!served_reg) begin
                wait_reg <= wait_reg + 8'h01;
            end
        end
    end
endmodule : spl_mem_model

// ===== bench/spl_loader_bench.sv
// Self-checking bench of the power-up loader
`timescale 1ns/10ps
`include "spl_cfg.svh"
module spl_loader_bench;
    logic i_ref_clk;
    logic i_reset_n;
    logic sig_valid;
    logic pm_enable;
    logic port_b;
    logic [7:0] pins_in;
    logic [7:0] delay;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [15:0] word_power;
    spl_pkg::spl_bus_req_s bus;
    spl_pkg::spl_mem_req_s mem_req;
    spl_pkg::spl_mem_rsp_s mem_rsp;
    logic [15:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic phy_pm;
    logic wake_adv;
    logic ready;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    spl_pkg::spl_mem_req_s mem_req_r;
    spl_pkg::spl_mem_rsp_s mem_rsp_r;
    logic req_seen;
    int err_total;
    int samples_checked;

    spl_loader #(.DUAL_PORT(1'b1), .REDUCED_PINS(1'b0), .NUM_PINS(8)) i_dut (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_sig_valid(sig_valid), .i_pm_enable(pm_enable),
        .i_port_b(port_b), .o_mem_req(mem_req), .i_mem_rsp(mem_rsp),
        .i_bus(bus), .o_rdata(rdata), .i_soft_pin_in(pins_in),
        .o_soft_pin_out(pin_out), .o_soft_pin_oe(pin_oe),
        .o_phy_power_mgmt_enable(phy_pm),
        .o_deep_sleep_wake_advert(wake_adv), .o_regs_ready(ready)
    );

    spl_mem_model i_mem (
        .i_clk(i_ref_clk), .i_rst_n(i_reset_n), .i_delay(delay),
        .i_word_a(word_a), .i_word_b(word_b), .i_word_power(word_power),
        .i_mem_req(mem_req), .o_mem_rsp(mem_rsp)
    );

    // Reduced single-port variant on the same stimulus
    spl_loader #(.DUAL_PORT(1'b0), .REDUCED_PINS(1'b1), .NUM_PINS(8))
        i_dut_reduced (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_sig_valid(sig_valid), .i_pm_enable(pm_enable),
        .i_port_b(port_b), .o_mem_req(mem_req_r), .i_mem_rsp(mem_rsp_r),
        .i_bus(bus), .o_rdata(), .i_soft_pin_in(pins_in),
        .o_soft_pin_out(pin_out_r), .o_soft_pin_oe(pin_oe_r),
        .o_phy_power_mgmt_enable(), .o_deep_sleep_wake_advert(),
        .o_regs_ready()
    );

    spl_mem_model i_mem_reduced (
        .i_clk(i_ref_clk), .i_rst_n(i_reset_n), .i_delay(delay),
        .i_word_a(word_a), .i_word_b(word_b), .i_word_power(word_power),
        .i_mem_req(mem_req_r), .o_mem_rsp(mem_rsp_r)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task check16(input string what, input logic [15:0] exp,
                 input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check16

    task bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_ref_clk);
        bus <= '0;
    endtask : bus_write

    task read_check(input string what, input logic [7:0] a,
                    input logic [15:0] exp);
        @(posedge i_ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge i_ref_clk);
        bus <= '0;
        #1;
        check16(what, exp, rdata);
    endtask : read_check

    task start_reset;
        @(posedge i_ref_clk);
        i_reset_n <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
    endtask : start_reset

    task wait_ready;
        int n;
        n = 0;
        req_seen = 1'b0;
        while (ready !== 1'b1 && n < 400) begin
            @(posedge i_ref_clk);
            #1;
            req_seen = req_seen | (mem_req.req === 1'b1);
            n++;
        end
        check16("regs ready", 16'h0001, {15'h0000, ready});
    endtask : wait_ready

    // Loads one pin word and judges registers and pins
    task run_load(input logic [15:0] word, input logic [15:0] exp_dev,
                  input logic [15:0] exp_ext, input logic [7:0] exp_oe,
                  input logic [7:0] exp_out);
        word_a <= word;
        start_reset();
        wait_ready();
        read_check("ext ctrl", `SPL_REG_EXT_CTRL, exp_ext);
        check16("pin oe", {8'h00, exp_oe}, {8'h00, pin_oe});
        check16("pin out", {8'h00, exp_out}, {8'h00, pin_out});
        read_check("dev ctrl", `SPL_REG_DEV_CTRL, exp_dev);
        check16("dev bits", exp_dev, {14'h0000, wake_adv, phy_pm});
    endtask : run_load

    task t_default_word;
        run_load(16'hdfde, 16'h0003, 16'hc3c2, 8'hc3, 8'hc2);
        check16("unused oe", 16'h00c3, {8'h00, pin_oe});
        read_check("status", `SPL_REG_STATUS, 16'h0003);
        read_check("pin in", `SPL_REG_PIN_IN, 16'h00a5);
    endtask : t_default_word

    // Reserved groups kept zero, unused pins left as undriven inputs
    task t_pin_bits;
        run_load(16'h8142, 16'h0000, 16'h8142, 8'h81, 8'h00);
        run_load(16'h4281, 16'h0000, 16'h4281, 8'h42, 8'h00);
        run_load(16'hc1c3, 16'h0000, 16'hc1c3, 8'hc1, 8'hc1);
        run_load(16'h0303, 16'h0000, 16'h0303, 8'h03, 8'h03);
        run_load(16'h00c3, 16'h0000, 16'h00c3, 8'h00, 8'h00);
        run_load(16'h00c0, 16'h0000, 16'h00c0, 8'h00, 8'h00);
        run_load(16'h0008, 16'h0001, 16'h0000, 8'h00, 8'h00);
        run_load(16'h0004, 16'h0002, 16'h0000, 8'h00, 8'h00);
    endtask : t_pin_bits

    task t_power;
        int s;
        word_power <= 16'h002a;
        run_load(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00);
        for (s = 0; s < 16; s++) begin
            bus_write(`SPL_REG_PM_CSR, 16'(s) << 9);
            read_check("pm data", `SPL_REG_PM_DATA,
                       (s == 8) ? 16'h002a : 16'h0000);
        end
        bus_write(`SPL_REG_PM_CSR, 16'h1000);
        read_check("pm raw", `SPL_REG_PM_DATA, 16'h002a);
        @(posedge i_ref_clk);
        pm_enable <= 1'b0;
        read_check("pm off", `SPL_REG_PM_DATA, 16'h0000);
        @(posedge i_ref_clk);
        pm_enable <= 1'b1;
    endtask : t_power

    task t_no_signature;
        @(posedge i_ref_clk);
        sig_valid <= 1'b0;
        run_load(16'hc1c3, 16'h0003, 16'h0000, 8'h00, 8'h00);
        check16("mem reads", 16'h0000, {15'h0000, req_seen});
        bus_write(`SPL_REG_PM_CSR, 16'h1000);
        read_check("pm nosig", `SPL_REG_PM_DATA, 16'h0000);
        read_check("status", `SPL_REG_STATUS, 16'h0001);
        @(posedge i_ref_clk);
        sig_valid <= 1'b1;
    endtask : t_no_signature

    task t_early_write;
        delay <= 8'd40;
        word_a <= 16'h8142;
        start_reset();
        repeat (5) @(posedge i_ref_clk);
        bus_write(`SPL_REG_EXT_CTRL, 16'hffff);
        bus_write(`SPL_REG_DEV_CTRL, 16'h0003);
        // The load never touches the selector, so a taken write would show
        bus_write(`SPL_REG_PM_CSR, 16'h1000);
        wait_ready();
        read_check("csr early", `SPL_REG_PM_CSR, 16'h0000);
        read_check("ext early", `SPL_REG_EXT_CTRL, 16'h8142);
        read_check("dev early", `SPL_REG_DEV_CTRL, 16'h0000);
        read_check("unmapped", 8'h3e, 16'h0000);
        delay <= 8'd0;
    endtask : t_early_write

    task t_port_select;
        word_b <= 16'h4281;
        @(posedge i_ref_clk);
        port_b <= 1'b1;
        run_load(16'h8142, 16'h0000, 16'h4281, 8'h42, 8'h00);
        check16("reduced oe", 16'h0009, {8'h00, pin_oe_r});
        @(posedge i_ref_clk);
        port_b <= 1'b0;
        run_load(16'hc1c3, 16'h0000, 16'hc1c3, 8'hc1, 8'hc1);
        check16("reduced oe", 16'h000d, {8'h00, pin_oe_r});
        check16("reduced out", 16'h000d, {8'h00, pin_out_r});
    endtask : t_port_select

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        finish_test();
    end

    initial begin
        i_reset_n = 1'b0;
        sig_valid = 1'b1;
        pm_enable = 1'b1;
        port_b = 1'b0;
        pins_in = 8'ha5;
        delay = 8'd0;
        word_a = 16'hdfde;
        word_b = 16'h0000;
        word_power = 16'h0000;
        bus = '0;
        err_total = 0;
        samples_checked = 0;
        t_default_word();
        t_pin_bits();
        t_power();
        t_no_signature();
        t_early_write();
        t_port_select();
        finish_test();
    end
endmodule : spl_loader_bench
